// file: src/pfs_pkg.sv
// Package with the register map, field layouts and carrier types of the port-1 pin function select block.
//
// Contract
// - First pin bit 7 routes it to touch key 9, only with analog enable set.
// - First pin bit 6 drives the pad with the enhanced LIN UART transmit output.
// - First pin bit 5 drives the pad with the classic UART transmit output.
// - First pin bit 4 makes the pad the capture/compare/PWM pin of module 5.
// - First pin bit 3 feeds the pad to the SPI as slave-select input.
// - Bit 2 of either register adds that pin's input to interrupt line B.
// - Bit 1 of either register adds that pin's input to interrupt line A.
// - Each interrupt line combines every selected pin's condition at once.
// - One pin may feed both interrupt lines independently at the same time.
// - Bit 0 of either register enables plain general-purpose I/O on that pin.
// - Reset clears every select bit, so all functions start disabled.

package pfs_pkg;

  localparam int unsigned PFS_ADDR_W = 16;
  localparam int unsigned PFS_DATA_W = 8;
  localparam int unsigned PFS_NUM_PINS = 2;

  localparam logic [PFS_ADDR_W-1:0] PFS_P11_CFG_OFS = 16'ha059;
  localparam logic [PFS_ADDR_W-1:0] PFS_P12_CFG_OFS = 16'ha05a;
  localparam logic [PFS_DATA_W-1:0] PFS_CFG_RST     = 8'h00;
  localparam logic [PFS_DATA_W-1:0] PFS_UNMAPPED_RD = 8'h00;

  // Bit positions shared by every pin register.
  localparam int unsigned PFS_BIT_GPIO  = 0;
  localparam int unsigned PFS_BIT_IRQ_A = 1;
  localparam int unsigned PFS_BIT_IRQ_B = 2;

  // Pin index within the register array.
  localparam int unsigned PFS_PIN_P11 = 0;
  localparam int unsigned PFS_PIN_P12 = 1;

  typedef struct packed {
    logic touch_key_9_sel;
    logic enh_uart_tx_sel;
    logic std_uart_tx_sel;
    logic ccp_ch5_pin_sel;
    logic spi_slave_select_sel;
    logic pin_irq_b_source_sel;
    logic pin_irq_a_source_sel;
    logic general_io_enable;
  } pfs_p11_cfg_t;

  typedef struct packed {
    logic touch_key_10_sel;
    logic i2c_master_data_sel;
    logic i2c_slave2_data_sel;
    logic pwm_ch0_out_sel;
    logic spi_mosi_sel;
    logic pin_irq_b_source_sel;
    logic pin_irq_a_source_sel;
    logic general_io_enable;
  } pfs_p12_cfg_t;

  // Digital drive of one pad: level and output enable.
  typedef struct packed {
    logic out;
    logic oe;
  } pfs_pad_t;

  localparam pfs_pad_t PFS_PAD_IDLE = '{out: 1'b0, oe: 1'b0};

endpackage

// file: src/pfs_port1_pin_function_select.sv
// Register pair and pad multiplexer for two port-1 pins.
`timescale 1ns/1ps
`default_nettype none

module pfs_port1_pin_function_select
  import pfs_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  // Register port.
  input  wire logic [PFS_ADDR_W-1:0] reg_addr_i,
  input  wire logic [PFS_DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [PFS_DATA_W-1:0] reg_rdata_o,
  // Pads: input level, output level, output enable.
  input  wire logic                  p11_pad_i,
  output logic                       p11_pad_o,
  output logic                       p11_pad_oe_o,
  input  wire logic                  p12_pad_i,
  output logic                       p12_pad_o,
  output logic                       p12_pad_oe_o,
  // Analog enables from the separate I/O configuration registers.
  input  wire logic                  p11_analog_pad_enable_i,
  input  wire logic                  p12_analog_pad_enable_i,
  // Touch-key channel connections.
  output logic                       touch_key_9_en_o,
  output logic                       touch_key_10_en_o,
  // UART transmitters.
  input  wire logic                  enhanced_lin_uart_txd_i,
  input  wire logic                  classic_uart_txd_i,
  // Capture/compare/PWM module 5 pin.
  input  wire logic                  counter_array_module_5_out_i,
  input  wire logic                  counter_array_module_5_oe_i,
  output logic                       counter_array_module_5_in_o,
  // SPI controller.
  output logic                       spi_ssn_n_o,
  input  wire logic                  spi_mosi_out_i,
  input  wire logic                  spi_mosi_oe_i,
  output logic                       spi_mosi_in_o,
  // I2C data lines; a low request pulls the line, a high one releases it.
  input  wire logic                  i2c_master_sda_out_i,
  output logic                       i2c_master_sda_in_o,
  input  wire logic                  i2c_slave2_sda_out_i,
  output logic                       i2c_slave2_sda_in_o,
  // PWM channel 0.
  input  wire logic                  pwm_ch0_out_i,
  // General-purpose I/O per pin.
  input  wire logic [PFS_NUM_PINS-1:0] gpio_out_i,
  input  wire logic [PFS_NUM_PINS-1:0] gpio_oe_i,
  output logic      [PFS_NUM_PINS-1:0] gpio_in_o,
  // Shared pin-interrupt conditions.
  output logic                       pin_irq_a_o,
  output logic                       pin_irq_b_o
);

  // One-hot register hit for an address.
  function automatic logic [PFS_NUM_PINS-1:0] pfs_hit(input logic [PFS_ADDR_W-1:0] addr);
    logic [PFS_NUM_PINS-1:0] hit;
    hit = '0;
    hit[PFS_PIN_P11] = (addr == PFS_P11_CFG_OFS);
    hit[PFS_PIN_P12] = (addr == PFS_P12_CFG_OFS);
    return hit;
  endfunction

  logic [PFS_DATA_W-1:0]   cfg_q [PFS_NUM_PINS];
  logic [PFS_NUM_PINS-1:0] wr_hit;
  logic [PFS_NUM_PINS-1:0] rd_hit;
  logic [PFS_NUM_PINS-1:0] pad_in;
  logic [PFS_NUM_PINS-1:0] irq_a_sel;
  logic [PFS_NUM_PINS-1:0] irq_b_sel;
  logic [PFS_NUM_PINS-1:0] gpio_sel;
  pfs_p11_cfg_t            p11_cfg;
  pfs_p12_cfg_t            p12_cfg;
  pfs_pad_t                p11_pad_d;
  pfs_pad_t                p12_pad_d;

  // Individual selects, named after the function that each one hands the pad to.
  logic                    p11_touch_sel;
  logic                    p11_enh_tx_sel;
  logic                    p11_std_tx_sel;
  logic                    p11_ccp_sel;
  logic                    p11_ssn_sel;
  logic                    p12_touch_sel;
  logic                    p12_master_sda_sel;
  logic                    p12_slave_sda_sel;
  logic                    p12_pwm_sel;
  logic                    p12_mosi_sel;
  logic                    p11_touch_conn;
  logic                    p12_touch_conn;
  logic [PFS_NUM_PINS-1:0] irq_a_hit;
  logic [PFS_NUM_PINS-1:0] irq_b_hit;

  assign wr_hit  = reg_wr_i ? pfs_hit(reg_addr_i) : '0;
  assign rd_hit  = reg_rd_i ? pfs_hit(reg_addr_i) : '0;
  assign p11_cfg = pfs_p11_cfg_t'(cfg_q[PFS_PIN_P11]);
  assign p12_cfg = pfs_p12_cfg_t'(cfg_q[PFS_PIN_P12]);
  assign pad_in  = {p12_pad_i, p11_pad_i};

  assign p11_touch_sel      = p11_cfg.touch_key_9_sel;
  assign p11_enh_tx_sel     = p11_cfg.enh_uart_tx_sel;
  assign p11_std_tx_sel     = p11_cfg.std_uart_tx_sel;
  assign p11_ccp_sel        = p11_cfg.ccp_ch5_pin_sel;
  assign p11_ssn_sel        = p11_cfg.spi_slave_select_sel;
  assign p12_touch_sel      = p12_cfg.touch_key_10_sel;
  assign p12_master_sda_sel = p12_cfg.i2c_master_data_sel;
  assign p12_slave_sda_sel  = p12_cfg.i2c_slave2_data_sel;
  assign p12_pwm_sel        = p12_cfg.pwm_ch0_out_sel;
  assign p12_mosi_sel       = p12_cfg.spi_mosi_sel;

  // A touch channel only takes the pad while its analog path is open as well.
  assign p11_touch_conn = p11_touch_sel & p11_analog_pad_enable_i;
  assign p12_touch_conn = p12_touch_sel & p12_analog_pad_enable_i;

  genvar g;
  generate
    for (g = 0; g < PFS_NUM_PINS; g++) begin : g_pin
      // Each register holds all eight written bits unchanged.
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          cfg_q[g] <= PFS_CFG_RST;
        end else if (wr_hit[g]) begin
          cfg_q[g] <= reg_wdata_i;
        end
      end

      assign irq_a_sel[g] = cfg_q[g][PFS_BIT_IRQ_A];
      assign irq_b_sel[g] = cfg_q[g][PFS_BIT_IRQ_B];
      assign gpio_sel[g]  = cfg_q[g][PFS_BIT_GPIO];
      assign irq_a_hit[g] = irq_a_sel[g] & pad_in[g];
      assign irq_b_hit[g] = irq_b_sel[g] & pad_in[g];

      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          gpio_in_o[g] <= 1'b0;
        end else begin
          gpio_in_o[g] <= gpio_sel[g] & pad_in[g];
        end
      end
    end
  endgenerate

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= PFS_UNMAPPED_RD;
    end else if (rd_hit[PFS_PIN_P11]) begin
      reg_rdata_o <= cfg_q[PFS_PIN_P11];
    end else if (rd_hit[PFS_PIN_P12]) begin
      reg_rdata_o <= cfg_q[PFS_PIN_P12];
    end else begin
      reg_rdata_o <= PFS_UNMAPPED_RD;
    end
  end

  // First pin drive, highest bit wins when several are set; bit 7 counts only while the analog enable is set.
  always_comb begin
    p11_pad_d = PFS_PAD_IDLE;
    if (p11_touch_conn) begin
      p11_pad_d = PFS_PAD_IDLE;
    end else if (p11_enh_tx_sel) begin
      p11_pad_d.out = enhanced_lin_uart_txd_i;
      p11_pad_d.oe  = 1'b1;
    end else if (p11_std_tx_sel) begin
      p11_pad_d.out = classic_uart_txd_i;
      p11_pad_d.oe  = 1'b1;
    end else if (p11_ccp_sel) begin
      p11_pad_d.out = counter_array_module_5_out_i;
      p11_pad_d.oe  = counter_array_module_5_oe_i;
    end else if (p11_ssn_sel) begin
      p11_pad_d = PFS_PAD_IDLE;
    end else if (gpio_sel[PFS_PIN_P11]) begin
      p11_pad_d.out = gpio_out_i[PFS_PIN_P11];
      p11_pad_d.oe  = gpio_oe_i[PFS_PIN_P11];
    end
  end

  // Second pin drive; I2C data is driven open-drain: low or released.
  always_comb begin
    p12_pad_d = PFS_PAD_IDLE;
    if (p12_touch_conn) begin
      p12_pad_d = PFS_PAD_IDLE;
    end else if (p12_master_sda_sel) begin
      p12_pad_d.out = 1'b0;
      p12_pad_d.oe  = ~i2c_master_sda_out_i;
    end else if (p12_slave_sda_sel) begin
      p12_pad_d.out = 1'b0;
      p12_pad_d.oe  = ~i2c_slave2_sda_out_i;
    end else if (p12_pwm_sel) begin
      p12_pad_d.out = pwm_ch0_out_i;
      p12_pad_d.oe  = 1'b1;
    end else if (p12_mosi_sel) begin
      p12_pad_d.out = spi_mosi_out_i;
      p12_pad_d.oe  = spi_mosi_oe_i;
    end else if (gpio_sel[PFS_PIN_P12]) begin
      p12_pad_d.out = gpio_out_i[PFS_PIN_P12];
      p12_pad_d.oe  = gpio_oe_i[PFS_PIN_P12];
    end
  end

  // Pad levels and enables are registered so the pads never see decode glitches.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      p11_pad_o <= 1'b0;
    end else begin
      p11_pad_o <= p11_pad_d.out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      p11_pad_oe_o <= 1'b0;
    end else begin
      p11_pad_oe_o <= p11_pad_d.oe;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      p12_pad_o <= 1'b0;
    end else begin
      p12_pad_o <= p12_pad_d.out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      p12_pad_oe_o <= 1'b0;
    end else begin
      p12_pad_oe_o <= p12_pad_d.oe;
    end
  end

  // Touch-key channels need the analog enable of the pad as well.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      touch_key_9_en_o <= 1'b0;
    end else begin
      touch_key_9_en_o <= p11_touch_conn;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      touch_key_10_en_o <= 1'b0;
    end else begin
      touch_key_10_en_o <= p12_touch_conn;
    end
  end

  // Peripheral inputs rest at their idle levels when the pin is not theirs.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      counter_array_module_5_in_o <= 1'b0;
    end else begin
      counter_array_module_5_in_o <= p11_ccp_sel & p11_pad_i;
    end
  end

  // Slave select idles high so a deselected controller never sees itself chosen.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      spi_ssn_n_o <= 1'b1;
    end else begin
      spi_ssn_n_o <= p11_ssn_sel ? p11_pad_i : 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      spi_mosi_in_o <= 1'b0;
    end else begin
      spi_mosi_in_o <= p12_mosi_sel & p12_pad_i;
    end
  end

  // Released I2C data reads high, as the bus pull-up would leave it.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      i2c_master_sda_in_o <= 1'b1;
    end else begin
      i2c_master_sda_in_o <= p12_master_sda_sel ? p12_pad_i : 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      i2c_slave2_sda_in_o <= 1'b1;
    end else begin
      i2c_slave2_sda_in_o <= p12_slave_sda_sel ? p12_pad_i : 1'b1;
    end
  end

  // Each line is the OR of every pin selected for it; the two are independent.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_irq_a_o <= 1'b0;
    end else begin
      pin_irq_a_o <= |irq_a_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_irq_b_o <= 1'b0;
    end else begin
      pin_irq_b_o <= |irq_b_hit;
    end
  end

endmodule

`default_nettype wire

// file: testbench/pfs_properties.sv
// Port-level assertions for the port-1 pin function select block.
`timescale 1ns/1ps
`default_nettype none
module pfs_properties
  import pfs_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    resetn_i,
  input wire logic [PFS_ADDR_W-1:0]   reg_addr_i,
  input wire logic [PFS_DATA_W-1:0]   reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [PFS_DATA_W-1:0]   reg_rdata_o,
  input wire logic                    p11_pad_i,
  input wire logic                    p12_pad_i,
  input wire logic                    p11_pad_oe_o,
  input wire logic                    p11_analog_pad_enable_i,
  input wire logic                    touch_key_9_en_o,
  input wire logic                    counter_array_module_5_in_o,
  input wire logic                    spi_ssn_n_o,
  input wire logic [PFS_NUM_PINS-1:0] gpio_in_o,
  input wire logic                    pin_irq_a_o,
  input wire logic                    pin_irq_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_touch_needs_analog: assert property (touch_key_9_en_o |-> $past(p11_analog_pad_enable_i))
    else $error("touch key 9 connected without analog enable");
  a_touch_no_drive: assert property (touch_key_9_en_o |-> !p11_pad_oe_o)
    else $error("pad driven while touch key 9 connected");
  a_ccp_in_pad: assert property (counter_array_module_5_in_o |-> $past(p11_pad_i))
    else $error("capture input high without pad high");
  a_ssn_follows_pad: assert property (!spi_ssn_n_o |-> !$past(p11_pad_i))
    else $error("slave select low while pad high");
  a_irq_b_source: assert property (pin_irq_b_o |-> $past(p11_pad_i) || $past(p12_pad_i))
    else $error("line B raised with both pads low");
  a_irq_a_source: assert property (pin_irq_a_o |-> $past(p11_pad_i) || $past(p12_pad_i))
    else $error("line A raised with both pads low");
  a_gpio_in_pad: assert property (gpio_in_o[0] |-> $past(p11_pad_i))
    else $error("gpio input high without pad high");
  a_reset_clears: assert property (disable iff (1'b0) !resetn_i |=> reg_rdata_o == 8'h00 && spi_ssn_n_o)
    else $error("outputs not at reset values");
  a_read_after_write: assert property (reg_wr_i && reg_addr_i == PFS_P11_CFG_OFS ##1
    reg_rd_i && reg_addr_i == PFS_P11_CFG_OFS |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("read data differs from value written");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
endmodule

bind pfs_port1_pin_function_select pfs_properties u_props (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .p11_pad_i, .p12_pad_i, .p11_pad_oe_o, .p11_analog_pad_enable_i,
  .touch_key_9_en_o, .counter_array_module_5_in_o, .spi_ssn_n_o, .gpio_in_o, .pin_irq_a_o, .pin_irq_b_o);
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the port-1 pin function select block.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pfs_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        look = 1'b0;
  logic        rd_seen = 1'b0;
  logic        look_seen = 1'b0;
  logic [15:0] addr = '0;
  logic [7:0]  wd = '0;
  logic [16:0] r = '0;
  logic [7:0]  rdata;
  logic [14:0] q[$];
  logic [14:0] exp_v;
  logic [14:0] got;
  logic        p11o, p11e, p12o, p12e, tk9, tk10, ccpi, ssn, sdam, sdas, mosi, ia, ib;
  logic [1:0]  gin;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  wire [14:0]  stat = {ib, ia, p12e, p12o, p11e, p11o, tk10, tk9, ssn, ccpi, sdam, sdas, mosi, gin};

  always #50 clk_i = ~clk_i;

  pfs_port1_pin_function_select dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .p11_pad_i(r[2]),
    .p11_pad_o(p11o), .p11_pad_oe_o(p11e), .p12_pad_i(r[3]), .p12_pad_o(p12o), .p12_pad_oe_o(p12e),
    .p11_analog_pad_enable_i(r[0]), .p12_analog_pad_enable_i(r[1]), .touch_key_9_en_o(tk9),
    .touch_key_10_en_o(tk10), .enhanced_lin_uart_txd_i(r[4]), .classic_uart_txd_i(r[5]),
    .counter_array_module_5_out_i(r[6]), .counter_array_module_5_oe_i(r[7]), .counter_array_module_5_in_o(ccpi), .spi_ssn_n_o(ssn), .spi_mosi_out_i(r[8]),
    .spi_mosi_oe_i(r[9]), .spi_mosi_in_o(mosi), .i2c_master_sda_out_i(r[10]), .i2c_master_sda_in_o(sdam),
    .i2c_slave2_sda_out_i(r[11]), .i2c_slave2_sda_in_o(sdas), .pwm_ch0_out_i(r[12]), .gpio_out_i(r[14:13]),
    .gpio_oe_i(r[16:15]), .gpio_in_o(gin), .pin_irq_a_o(ia), .pin_irq_b_o(ib));

  // Expected pins from both configurations and the present inputs; pad drive is {oe, out}.
  function automatic logic [14:0] model(input logic [7:0] a, input logic [7:0] b);
    logic [1:0] d1;
    logic [1:0] d2;
    d1 = 2'b00;
    d2 = 2'b00;
    if (a[7] && r[0]) d1 = 2'b00;
    else if (a[6]) d1 = {1'b1, r[4]};
    else if (a[5]) d1 = {1'b1, r[5]};
    else if (a[4]) d1 = {r[7], r[6]};
    else if (a[3]) d1 = 2'b00;
    else if (a[0]) d1 = {r[15], r[13]};
    if (b[7] && r[1]) d2 = 2'b00;
    else if (b[6]) d2 = {~r[10], 1'b0};
    else if (b[5]) d2 = {~r[11], 1'b0};
    else if (b[4]) d2 = {1'b1, r[12]};
    else if (b[3]) d2 = {r[9], r[8]};
    else if (b[0]) d2 = {r[16], r[14]};
    return {(a[2] & r[2]) | (b[2] & r[3]), (a[1] & r[2]) | (b[1] & r[3]), d2, d1, b[7] & r[1],
      a[7] & r[0], ~a[3] | r[2], a[4] & r[2], ~b[6] | r[3], ~b[5] | r[3], b[3] & r[3], b[0] & r[3], a[0] & r[2]};
  endfunction

  task automatic bus(input logic w, input logic rr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= w;
    rd <= rr;
    addr <= a;
    wd <= d;
    if (rr) q.push_back({7'h00, d});
  endtask

  task automatic peek(input logic [7:0] a, input logic [7:0] b);
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
    look <= 1'b1;
    q.push_back(model(a, b));
    @(posedge clk_i);
    look <= 1'b0;
  endtask

  task automatic run(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_i);
    r <= 17'($urandom);
    bus(1'b1, 1'b0, PFS_P11_CFG_OFS, a);
    bus(1'b0, 1'b1, PFS_P11_CFG_OFS, a);
    bus(1'b1, 1'b0, PFS_P12_CFG_OFS, b);
    bus(1'b0, 1'b1, PFS_P12_CFG_OFS, b);
    bus(1'b1, 1'b0, 16'ha05b, ~a);
    bus(1'b0, 1'b1, 16'ha05b, PFS_UNMAPPED_RD);
    peek(a, b);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    rd_seen <= rd;
    look_seen <= look;
    cyc <= cyc + 1;
  end

  always @(negedge clk_i) begin
    if (rd_seen || look_seen) begin
      exp_v = (q.size() > 0) ? q.pop_front() : 15'h7fff;
      got = look_seen ? stat : {7'h00, rdata};
      n_compared++;
      if (got !== exp_v) begin
        fail_count++;
        $display("unexpected %s expected %h seen %h", look_seen ? "pins" : "rdata", exp_v, got);
      end
    end
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h6213c367));
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(1'b0, 1'b1, PFS_P11_CFG_OFS, PFS_CFG_RST);
    bus(1'b0, 1'b1, PFS_P12_CFG_OFS, PFS_CFG_RST);
    peek(8'h00, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) run(8'h01 << i, 8'h01 << i);
    repeat (60) run(8'($urandom), 8'($urandom));
    $display("test selects done");
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(1'b0, 1'b1, PFS_P11_CFG_OFS, PFS_CFG_RST);
    bus(1'b0, 1'b1, PFS_P12_CFG_OFS, PFS_CFG_RST);
    peek(8'h00, 8'h00);
    $display("test second reset done");
    repeat (3) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
`default_nettype wire
